// ---- rtl/sio_pkg.sv ----
package sio_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_C_DATA = 8'h02;
  localparam logic [7:0] OFS_PORT_D_DATA = 8'h03;
  localparam logic [7:0] OFS_PORT_C_DIR  = 8'h06;
  localparam logic [7:0] OFS_PORT_D_DIR  = 8'h07;
  localparam logic [7:0] OFS_PORT_E_DATA = 8'h08;
  localparam logic [7:0] OFS_PORT_E_DIR  = 8'h0c;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int         PC_WIDTH  = 6;
  localparam int         PD_WIDTH  = 8;
  localparam int         PE_WIDTH  = 8;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Port C clock output
  // ----------------------------------------------------------------
  localparam int CLK_OUT_EN_BIT = 7;
  localparam int CLK_OUT_PIN    = 2;

  // ----------------------------------------------------------------
  // Port D sharing
  // ----------------------------------------------------------------
  localparam logic [4:0] ADC_FIRST_CHAN   = 5'h08;
  localparam logic [4:0] ADC_LAST_CHAN    = 5'h0e;
  localparam logic [2:0] PRESCALE_EXT_CLK = 3'h7;
  localparam int         TA_CLK_PIN       = 6;
  localparam int         TB_CLK_PIN       = 4;

  // ----------------------------------------------------------------
  // Port E sharing
  // ----------------------------------------------------------------
  localparam int         SCK_PIN   = 7;
  localparam int         MOSI_PIN  = 6;
  localparam int         MISO_PIN  = 5;
  localparam int         SS_PIN    = 4;
  localparam int         TCH1_PIN  = 3;
  localparam int         TCH0_PIN  = 2;
  localparam int         RXD_PIN   = 1;
  localparam int         TXD_PIN   = 0;
  localparam logic [1:0] ELS_PIN_IO = 2'h0;

endpackage

// ---- rtl/sio_port.sv ----
`timescale 1ns/100ps

module sio_port #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  // Register writes
  input  wire logic [7:0]       wr_data_i,
  input  wire logic             wr_latch_i,
  input  wire logic             wr_dir_i,
  input  wire logic [WIDTH-1:0] latch_keep_i,
  // State
  output logic      [WIDTH-1:0] latch_o,
  output logic      [WIDTH-1:0] dir_o
);

  // Slice serves at most one byte of pins
  if (WIDTH < 1 || WIDTH > 8)
  begin
    $error("sio_port width must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // Data latches: no reset, writes land whatever the direction
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_latch_i)
      latch_o <= (wr_data_i[WIDTH-1:0] & ~latch_keep_i)
               | (latch_o & latch_keep_i);
  end

  // ----------------------------------------------------------------
  // Direction bits
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      dir_o <= sio_pkg::DIR_RESET[WIDTH-1:0];
    else if (wr_dir_i)
      dir_o <= wr_data_i[WIDTH-1:0];
  end

endmodule

// ---- rtl/sio_owner.sv ----
`timescale 1ns/100ps

module sio_owner (
  // Converter and timers
  input  wire logic [4:0] converter_channel_select_i,
  input  wire logic [2:0] ta_prescaler_select_i,
  input  wire logic [2:0] tb_prescaler_select_i,
  input  wire logic [1:0] ch0_edge_level_select_i,
  input  wire logic [1:0] ch1_edge_level_select_i,
  // Serial modules
  input  wire logic       sync_serial_enable_i,
  input  wire logic       sync_serial_master_select_i,
  input  wire logic       mode_fault_enable_i,
  input  wire logic       async_serial_enable_i,
  // Ownership masks
  output logic      [7:0] d_zero_o,
  output logic      [7:0] e_owned_o
);

  logic [4:0] adc_idx;

  always_comb
  begin
    adc_idx  = converter_channel_select_i - sio_pkg::ADC_FIRST_CHAN;
    d_zero_o = sio_pkg::ZERO_BYTE;
    if (converter_channel_select_i >= sio_pkg::ADC_FIRST_CHAN
        && converter_channel_select_i <= sio_pkg::ADC_LAST_CHAN)
      d_zero_o[adc_idx[2:0]] = 1'b1;
    if (ta_prescaler_select_i == sio_pkg::PRESCALE_EXT_CLK)
      d_zero_o[sio_pkg::TA_CLK_PIN] = 1'b1;
    if (tb_prescaler_select_i == sio_pkg::PRESCALE_EXT_CLK)
      d_zero_o[sio_pkg::TB_CLK_PIN] = 1'b1;
  end

  always_comb
  begin
    e_owned_o = sio_pkg::ZERO_BYTE;
    e_owned_o[sio_pkg::SCK_PIN]  = sync_serial_enable_i;
    e_owned_o[sio_pkg::MOSI_PIN] = sync_serial_enable_i;
    e_owned_o[sio_pkg::MISO_PIN] = sync_serial_enable_i;
    e_owned_o[sio_pkg::SS_PIN]   = sync_serial_enable_i
      && !(sync_serial_master_select_i && !mode_fault_enable_i);
    e_owned_o[sio_pkg::TCH1_PIN] = ch1_edge_level_select_i != sio_pkg::ELS_PIN_IO;
    e_owned_o[sio_pkg::TCH0_PIN] = ch0_edge_level_select_i != sio_pkg::ELS_PIN_IO;
    e_owned_o[sio_pkg::RXD_PIN]  = async_serial_enable_i;
    e_owned_o[sio_pkg::TXD_PIN]  = async_serial_enable_i;
  end

endmodule

// ---- rtl/sio_ports.sv ----
`timescale 1ns/100ps

// Operation
// - Direction one enables the pin driver; zero makes the pin an input.
// - Clock-output enable drives clock on port C pin 2; reset clears it.
// - Reset clears all direction bits of ports C, D and E.
// - Data writes update the latch, except bit C2 while clock output is enabled, never the input level.
// - Converter channel select decides which port D pins are converter inputs.
// - Converter-selected port D bit reads zero as input, else the latch.
// - Timer-used port D pins ignore direction; reads give latch or zero.
// - Prescaler select takes port D pins 6 and 4 as timer clocks.
// - Sync serial enable hands port E pins 7, 6 and 5 to serial.
// - Port E pin 4 is general unless slave mode, or master mode with mode fault enable, owns it.
// - Peripheral-owned port E pins ignore direction; reads still use it.
// - Edge/level select hands port E pins 3 and 2 to the timer.
// - Async serial enable hands port E pins 1 and 0 to serial.
// - With clock-output enable set, the system clock divided by two leaves on pin C2.
// - Reset leaves the port C data latches unchanged.
module sio_ports (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rd_data_o,
  // Pin levels
  input  wire logic [5:0] pc_pin_i,
  input  wire logic [7:0] pd_pin_i,
  input  wire logic [7:0] pe_pin_i,
  // Pin drivers
  output logic      [5:0] pc_out_o,
  output logic      [5:0] pc_oe_o,
  output logic      [7:0] pd_out_o,
  output logic      [7:0] pd_oe_o,
  output logic      [7:0] pe_out_o,
  output logic      [7:0] pe_oe_o,
  // Converter and timer controls
  input  wire logic [4:0] converter_channel_select_i,
  input  wire logic [2:0] ta_prescaler_select_i,
  input  wire logic [2:0] tb_prescaler_select_i,
  input  wire logic [1:0] ch0_edge_level_select_i,
  input  wire logic [1:0] ch1_edge_level_select_i,
  input  wire logic [1:0] timer_a_channel_out_i,
  input  wire logic [1:0] timer_a_channel_oe_i,
  // Serial controls
  input  wire logic       sync_serial_enable_i,
  input  wire logic       sync_serial_master_select_i,
  input  wire logic       mode_fault_enable_i,
  input  wire logic [3:0] sync_serial_out_i,
  input  wire logic [3:0] sync_serial_oe_i,
  input  wire logic       async_serial_enable_i,
  input  wire logic       async_serial_txd_i
);

  localparam int CP = sio_pkg::CLK_OUT_PIN;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [5:0] pc_latch;
  logic [5:0] pc_dir;
  logic [7:0] pd_latch;
  logic [7:0] pd_dir;
  logic [7:0] pe_latch;
  logic [7:0] pe_dir;
  logic       clock_out_enable;
  logic       clk_div;
  logic [7:0] d_zero;
  logic [7:0] e_owned;
  logic [5:0] pc_keep;
  logic [7:0] e_per_out;
  logic [7:0] e_per_oe;
  logic [5:0] pc_rd_zero;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_pc_data;
  logic wr_pc_dir;
  logic wr_pd_data;
  logic wr_pd_dir;
  logic wr_pe_data;
  logic wr_pe_dir;

  assign wr_pc_data = wr_i && addr_i == sio_pkg::OFS_PORT_C_DATA;
  assign wr_pc_dir  = wr_i && addr_i == sio_pkg::OFS_PORT_C_DIR;
  assign wr_pd_data = wr_i && addr_i == sio_pkg::OFS_PORT_D_DATA;
  assign wr_pd_dir  = wr_i && addr_i == sio_pkg::OFS_PORT_D_DIR;
  assign wr_pe_data = wr_i && addr_i == sio_pkg::OFS_PORT_E_DATA;
  assign wr_pe_dir  = wr_i && addr_i == sio_pkg::OFS_PORT_E_DIR;

  // Clock pin latch bit is frozen while the clock owns the pin
  always_comb
  begin
    pc_keep     = '0;
    pc_keep[CP] = clock_out_enable;
    pc_rd_zero  = '0;
    pc_rd_zero[CP] = clock_out_enable;
  end

  // ----------------------------------------------------------------
  // Port slices
  // ----------------------------------------------------------------
  sio_port #(.WIDTH(sio_pkg::PC_WIDTH)) u_port_c (
    .ref_clk_i    (ref_clk_i),
    .sys_rst_i    (sys_rst_i),
    .wr_data_i    (wr_data_i),
    .wr_latch_i   (wr_pc_data),
    .wr_dir_i     (wr_pc_dir),
    .latch_keep_i (pc_keep),
    .latch_o      (pc_latch),
    .dir_o        (pc_dir)
  );

  sio_port #(.WIDTH(sio_pkg::PD_WIDTH)) u_port_d (
    .ref_clk_i    (ref_clk_i),
    .sys_rst_i    (sys_rst_i),
    .wr_data_i    (wr_data_i),
    .wr_latch_i   (wr_pd_data),
    .wr_dir_i     (wr_pd_dir),
    .latch_keep_i ('0),
    .latch_o      (pd_latch),
    .dir_o        (pd_dir)
  );

  sio_port #(.WIDTH(sio_pkg::PE_WIDTH)) u_port_e (
    .ref_clk_i    (ref_clk_i),
    .sys_rst_i    (sys_rst_i),
    .wr_data_i    (wr_data_i),
    .wr_latch_i   (wr_pe_data),
    .wr_dir_i     (wr_pe_dir),
    .latch_keep_i ('0),
    .latch_o      (pe_latch),
    .dir_o        (pe_dir)
  );

  sio_owner u_owner (
    .converter_channel_select_i  (converter_channel_select_i),
    .ta_prescaler_select_i       (ta_prescaler_select_i),
    .tb_prescaler_select_i       (tb_prescaler_select_i),
    .ch0_edge_level_select_i     (ch0_edge_level_select_i),
    .ch1_edge_level_select_i     (ch1_edge_level_select_i),
    .sync_serial_enable_i        (sync_serial_enable_i),
    .sync_serial_master_select_i (sync_serial_master_select_i),
    .mode_fault_enable_i         (mode_fault_enable_i),
    .async_serial_enable_i       (async_serial_enable_i),
    .d_zero_o                    (d_zero),
    .e_owned_o                   (e_owned)
  );

  // ----------------------------------------------------------------
  // Clock-output enable, kept in the port C direction register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      clock_out_enable <= 1'b0;
    else if (wr_pc_dir)
      clock_out_enable <= wr_data_i[sio_pkg::CLK_OUT_EN_BIT];
  end

  // Outputs must come from flops, so the pin carries half the system rate
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      clk_div <= 1'b0;
    else if (clock_out_enable)
      clk_div <= ~clk_div;
    else
      clk_div <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_mux(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input logic [7:0] pin,
    input logic [7:0] zero
  );
    rd_mux = (dir & latch) | (~dir & ~zero & pin);
  endfunction

  logic [7:0] next_rd_data;

  always_comb
  begin
    next_rd_data = sio_pkg::ZERO_BYTE;
    if (rd_i)
    begin
      case (addr_i)
        sio_pkg::OFS_PORT_C_DATA:
          next_rd_data = rd_mux({2'h0, pc_latch}, {2'h0, pc_dir}, {2'h0, pc_pin_i},
                                sio_pkg::ZERO_BYTE) & ~{2'h0, pc_rd_zero};
        sio_pkg::OFS_PORT_C_DIR:
          next_rd_data = {clock_out_enable, 1'b0, pc_dir};
        sio_pkg::OFS_PORT_D_DATA:
          next_rd_data = rd_mux(pd_latch, pd_dir, pd_pin_i, d_zero);
        sio_pkg::OFS_PORT_D_DIR:
          next_rd_data = pd_dir;
        sio_pkg::OFS_PORT_E_DATA:
          next_rd_data = rd_mux(pe_latch, pe_dir, pe_pin_i,
                                sio_pkg::ZERO_BYTE);
        sio_pkg::OFS_PORT_E_DIR:
          next_rd_data = pe_dir;
        default:
          next_rd_data = sio_pkg::ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rd_data_o <= sio_pkg::ZERO_BYTE;
    else
      rd_data_o <= next_rd_data;
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_comb
  begin
    e_per_out = {sync_serial_out_i, timer_a_channel_out_i, 1'b0, async_serial_txd_i};
    e_per_oe  = {sync_serial_oe_i, timer_a_channel_oe_i, 1'b0, 1'b1};
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pc_out_o <= '0;
      pc_oe_o  <= '0;
    end
    else
    begin
      pc_out_o     <= pc_latch;
      pc_oe_o      <= pc_dir;
      if (clock_out_enable)
      begin
        pc_out_o[CP] <= ~clk_div;
        pc_oe_o[CP]  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pd_out_o <= '0;
      pd_oe_o  <= '0;
    end
    else
    begin
      pd_out_o <= pd_latch;
      pd_oe_o  <= pd_dir & ~d_zero;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pe_out_o <= '0;
      pe_oe_o  <= '0;
    end
    else
    begin
      pe_out_o <= (pe_latch & ~e_owned) | (e_per_out & e_owned);
      pe_oe_o  <= (pe_dir & ~e_owned) | (e_per_oe & e_owned);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_dir_drives_c;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !clock_out_enable |=> pc_oe_o[0] == $past(pc_dir[0]) && pc_oe_o[CP] == $past(pc_dir[CP]);
  endproperty
  a_dir_drives_c: assert property (p_dir_drives_c)
    else $error("port C driver does not follow direction");

  property p_clk_pin_driven;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    clock_out_enable ##1 clock_out_enable |=> pc_oe_o[CP] && pc_out_o[CP] != $past(pc_out_o[CP]);
  endproperty
  a_clk_pin_driven: assert property (p_clk_pin_driven)
    else $error("clock output pin not toggling");

  property p_reset_inputs;
    @(posedge ref_clk_i)
    $fell(sys_rst_i) |-> pc_dir == '0 && pd_dir == '0 && pe_dir == '0 && !clock_out_enable;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("direction bits not cleared by reset");

  property p_read_e_latch;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_i && addr_i == sio_pkg::OFS_PORT_E_DATA && pe_dir == 8'hff
    |=> rd_data_o == $past(pe_latch);
  endproperty
  a_read_e_latch: assert property (p_read_e_latch)
    else $error("port E read does not return latch");

  property p_write_latch;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_pd_data |=> pd_latch == $past(wr_data_i);
  endproperty
  a_write_latch: assert property (p_write_latch)
    else $error("port D latch not updated by write");

  property p_adc_read_zero;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    rd_i && addr_i == sio_pkg::OFS_PORT_D_DATA
    && converter_channel_select_i == sio_pkg::ADC_FIRST_CHAN && !pd_dir[0]
    |=> rd_data_o[0] == 1'b0;
  endproperty
  a_adc_read_zero: assert property (p_adc_read_zero)
    else $error("converter pin read not zero");

  property p_timer_clk_input;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ta_prescaler_select_i == sio_pkg::PRESCALE_EXT_CLK |=> !pd_oe_o[sio_pkg::TA_CLK_PIN];
  endproperty
  a_timer_clk_input: assert property (p_timer_clk_input)
    else $error("timer clock pin is driven");

  property p_spi_owns;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    sync_serial_enable_i |=> pe_oe_o[sio_pkg::SCK_PIN] == $past(sync_serial_oe_i[3]);
  endproperty
  a_spi_owns: assert property (p_spi_owns)
    else $error("serial clock pin not under serial control");

  property p_ss_slave;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    sync_serial_enable_i && !sync_serial_master_select_i
    |=> pe_oe_o[sio_pkg::SS_PIN] == $past(sync_serial_oe_i[0]);
  endproperty
  a_ss_slave: assert property (p_ss_slave)
    else $error("slave select pin follows direction bit");

  property p_tch_owned;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ch0_edge_level_select_i != sio_pkg::ELS_PIN_IO
    |=> pe_oe_o[sio_pkg::TCH0_PIN] == $past(timer_a_channel_oe_i[0]);
  endproperty
  a_tch_owned: assert property (p_tch_owned)
    else $error("timer channel pin not under timer control");

  property p_sci_rx_input;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    async_serial_enable_i |=> !pe_oe_o[sio_pkg::RXD_PIN] && pe_oe_o[sio_pkg::TXD_PIN];
  endproperty
  a_sci_rx_input: assert property (p_sci_rx_input)
    else $error("async serial pins wrongly driven");

  property p_clk_pin_frozen;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    clock_out_enable && wr_pc_data |=> pc_latch[CP] == $past(pc_latch[CP]);
  endproperty
  a_clk_pin_frozen: assert property (p_clk_pin_frozen)
    else $error("clock pin latch changed by write");

endmodule

// ---- verif/sio_pin_model.sv ----
`timescale 1ns/100ps

module sio_pin_model #(
  parameter int WIDTH = 8
) (
  // Design side
  input  wire logic [WIDTH-1:0] out_i,
  input  wire logic [WIDTH-1:0] oe_i,
  // Outside driver
  input  wire logic [WIDTH-1:0] ext_i,
  // Resolved level
  output logic      [WIDTH-1:0] pin_o
);
  // Enabled driver wins; an idle pin shows the outside level
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

// ---- verif/sio_ports_bench.sv ----
`timescale 1ns/100ps

module sio_ports_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, txd = 1'b0;
  logic       ss_en = 1'b0, ss_mst = 1'b0, mfe = 1'b0, as_en = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, pd_ext = 8'hff, pe_ext = 8'h3c;
  logic [7:0] rdat, pd_pin, pe_pin, pd_out, pd_oe, pe_out, pe_oe;
  logic [5:0] pc_pin, pc_out, pc_oe;
  logic [5:0] pc_ext = 6'h15;
  logic [4:0] conv_sel = 5'h1f;
  logic [2:0] ta_pre = 3'h0, tb_pre = 3'h0;
  logic [1:0] els0 = 2'h0, els1 = 2'h0, ta_out = 2'h0, ta_oe = 2'h0;
  logic [3:0] ss_out = 4'h0, ss_oe = 4'h0;
  logic       v;
  int         err_total = 0, n_tests = 0;

  always #4 clk = ~clk;

  sio_ports i_sio_ports (
    .ref_clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rdat), .pc_pin_i(pc_pin), .pd_pin_i(pd_pin),
    .pe_pin_i(pe_pin), .pc_out_o(pc_out), .pc_oe_o(pc_oe), .pd_out_o(pd_out),
    .pd_oe_o(pd_oe), .pe_out_o(pe_out), .pe_oe_o(pe_oe),
    .converter_channel_select_i(conv_sel), .ta_prescaler_select_i(ta_pre),
    .tb_prescaler_select_i(tb_pre), .ch0_edge_level_select_i(els0),
    .ch1_edge_level_select_i(els1), .timer_a_channel_out_i(ta_out),
    .timer_a_channel_oe_i(ta_oe), .sync_serial_enable_i(ss_en),
    .sync_serial_master_select_i(ss_mst), .mode_fault_enable_i(mfe),
    .sync_serial_out_i(ss_out), .sync_serial_oe_i(ss_oe),
    .async_serial_enable_i(as_en), .async_serial_txd_i(txd)
  );

  sio_pin_model #(.WIDTH(6)) i_pc_model (.out_i(pc_out), .oe_i(pc_oe), .ext_i(pc_ext),
                                         .pin_o(pc_pin));
  sio_pin_model #(.WIDTH(8)) i_pd_model (.out_i(pd_out), .oe_i(pd_oe), .ext_i(pd_ext),
                                         .pin_o(pd_pin));
  sio_pin_model #(.WIDTH(8)) i_pe_model (.out_i(pe_out), .oe_i(pe_oe), .ext_i(pe_ext),
                                         .pin_o(pe_pin));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr   <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdat, exp);
  endtask

  // Pin outputs follow their cause one edge later
  task automatic wait_pins;
    @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_pins();
    chk({2'h0, pc_oe}, 8'h00);
    chk(pd_oe | pe_oe, 8'h00);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h07, 8'h00);
    rd_chk(8'h0c, 8'h00);
    rd_chk(8'h02, 8'h15);
    @(posedge clk);
    #1;
    chk(rdat, 8'h00);
    rd_chk(8'h05, 8'h00);
    // Port C: latch loaded before the driver turns on
    wr_reg(8'h02, 8'h2a);
    wr_reg(8'h06, 8'h0f);
    wait_pins();
    chk({2'h0, pc_oe}, 8'h0f);
    chk({4'h0, pc_out[3:0]}, 8'h0a);
    rd_chk(8'h02, 8'h1a);
    wr_reg(8'h02, 8'h05);
    rd_chk(8'h02, 8'h15);
    // Clock output mode
    wr_reg(8'h06, 8'h80);
    wait_pins();
    v = pc_out[2];
    chk({7'h0, pc_oe[2]}, 8'h01);
    wait_pins();
    chk({7'h0, pc_out[2]}, {7'h0, ~v});
    rd_chk(8'h06, 8'h80);
    rd_chk(8'h02, 8'h11);
    wr_reg(8'h02, 8'h3b);
    // Second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_pins();
    chk({7'h0, pc_oe[2]}, 8'h00);
    wr_reg(8'h06, 8'h3f);
    rd_chk(8'h02, 8'h3f);
    // Port D converter channels, one pin at a time
    wr_reg(8'h03, 8'hd1);
    wr_reg(8'h07, 8'h00);
    for (int k = 0; k < 7; k++)
    begin
      @(posedge clk);
      conv_sel <= sio_pkg::ADC_FIRST_CHAN + 5'(k);
      rd_chk(8'h03, 8'hff & ~(8'h01 << k));
    end
    wr_reg(8'h07, 8'hff);
    wait_pins();
    chk(pd_oe, 8'hbf);
    chk(pd_out, 8'hd1);
    rd_chk(8'h03, 8'hd1);
    // Port D timer clocks
    @(posedge clk);
    conv_sel <= 5'h1f;
    ta_pre   <= sio_pkg::PRESCALE_EXT_CLK;
    tb_pre   <= sio_pkg::PRESCALE_EXT_CLK;
    wait_pins();
    chk(pd_oe, 8'haf);
    rd_chk(8'h03, 8'hd1);
    wr_reg(8'h07, 8'h00);
    rd_chk(8'h03, 8'haf);
    @(posedge clk);
    ta_pre <= 3'h0;
    tb_pre <= 3'h0;
    // Port E general use, then peripherals take over
    wr_reg(8'h08, 8'h5a);
    wr_reg(8'h0c, 8'hff);
    wait_pins();
    chk(pe_oe, 8'hff);
    chk(pe_out, 8'h5a);
    @(posedge clk);
    ss_en  <= 1'b1;
    ss_oe  <= 4'ha;
    ss_out <= 4'hf;
    els0   <= 2'h1;
    els1   <= 2'h2;
    ta_out <= 2'h2;
    ta_oe  <= 2'h1;
    as_en  <= 1'b1;
    txd    <= 1'b1;
    wait_pins();
    chk(pe_oe, 8'ha5);
    chk(pe_out & pe_oe, 8'ha1);
    rd_chk(8'h08, 8'h5a);
    @(posedge clk);
    ss_mst <= 1'b1;
    wait_pins();
    chk(pe_oe, 8'hb5);
    wr_reg(8'h0c, 8'h00);
    rd_chk(8'h08, 8'hb9);
    wr_reg(8'h0c, 8'hff);
    @(posedge clk);
    ss_en <= 1'b0;
    els0  <= 2'h0;
    els1  <= 2'h0;
    as_en <= 1'b0;
    wait_pins();
    chk(pe_oe, 8'hff);
    chk(pe_out, 8'h5a);
    tally_and_finish();
  end
endmodule
